// [pkg/scdl_defines.vh]
// Constants for the serial control DAC loader.
`ifndef SCDL_DEFINES_VH
`define SCDL_DEFINES_VH

// Width of one serial word and of the holding register.
`define SCDL_WORD_W 12
// Width of the per-frame serial clock counter.
`define SCDL_CNT_W 5
// Saturation value of the per-frame serial clock counter.
`define SCDL_CNT_MAX 5'h1F
// Fewest serial clock cycles that make a frame valid.
`define SCDL_MIN_CLKS 5'h03
// Serial clock cycles in a full word.
`define SCDL_WORD_CLKS 5'h0C
// Bit of the received word that programs the output mode.
`define SCDL_MODE_BIT 11
// Reset value of the control DAC holding register.
`define SCDL_DAC_RST 12'h000
// Reset value of the programmed output mode, low means grounded.
`define SCDL_MODE_RST 1'h0
// Number of pins that pass the input synchroniser.
`define SCDL_SYNC_W 5
// Synchroniser reset levels: enable high, all other pins low.
`define SCDL_SYNC_RST 5'h04
// Positions of the pins in the synchroniser vector.
`define SCDL_PIN_CLK 0
`define SCDL_PIN_DATA 1
`define SCDL_PIN_EN_N 2
`define SCDL_PIN_SEL 3
`define SCDL_PIN_SW 4

`endif

// [verilog/scdl_sync.v]
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none

module scdl_sync #(
   parameter W = 5,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   // Clock and reset.
   input wire clock_i,
   input wire sys_rst_i,
   // Raw pins and filtered levels.
   input wire [W-1:0] async_i,
   output wire [W-1:0] level_o
);

   // ****************************************************************
   // Per-pin chain.
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_pin
         reg s1_r;
         reg s2_r;
         reg s3_r;
         reg lvl_r;
         // The level follows the pin once stages two and three agree.
         always @(posedge clock_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               s1_r <= RST_VAL[g];
               s2_r <= RST_VAL[g];
               s3_r <= RST_VAL[g];
               lvl_r <= RST_VAL[g];
            end else begin
               s1_r <= async_i[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  lvl_r <= s3_r;
               end
            end
         end
         assign level_o[g] = lvl_r;
      end
   endgenerate

endmodule
`default_nettype wire

// [verilog/scdl_loader.v]
// Serial control DAC loader: three-wire word load and output mode control.
//
// What this block does
// - Shift one data bit per rising clock
// - Enable falling edge starts a new load
// - Update DAC only on closing enable rise
// - Enable high: clock and data ignored
// - Mode select picks programmed or switch mode
`timescale 1ns/100ps
`default_nettype none
`include "scdl_defines.vh"

module scdl_loader (
   // Clock and reset.
   input wire clock_i,
   input wire sys_rst_i,
   // Serial load pins.
   input wire serial_bit_clk_i,
   input wire serial_data_in_i,
   input wire serial_load_enable_n_i,
   // Output mode pins.
   input wire output_mode_select_i,
   input wire output_mode_switch_i,
   // Control DAC word and mode.
   output wire [`SCDL_WORD_W-1:0] control_dac_output_o,
   output wire output_mode_normal_o,
   // Status.
   output wire load_busy_o,
   output wire dac_update_o,
   output wire frame_reject_o,
   output wire frame_overrun_o,
   output wire [`SCDL_CNT_W-1:0] frame_clk_count_o
);

   // ****************************************************************
   // States.
   // ****************************************************************
   localparam [0:0] ST_IDLE = 1'b0;
   localparam [0:0] ST_LOAD = 1'b1;

   // ****************************************************************
   // Pin synchronisation.
   // ****************************************************************
   wire [`SCDL_SYNC_W-1:0] pins_raw;
   wire [`SCDL_SYNC_W-1:0] pins_lvl;

   assign pins_raw = {output_mode_switch_i, output_mode_select_i, serial_load_enable_n_i,
                      serial_data_in_i, serial_bit_clk_i};

   scdl_sync #(
      .W(`SCDL_SYNC_W),
      .RST_VAL(`SCDL_SYNC_RST)
   ) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .async_i(pins_raw),
      .level_o(pins_lvl)
   );

   wire sclk_lvl;
   wire sdata_lvl;
   wire en_n_lvl;
   wire sel_lvl;
   wire sw_lvl;

   assign sclk_lvl = pins_lvl[`SCDL_PIN_CLK];
   assign sdata_lvl = pins_lvl[`SCDL_PIN_DATA];
   assign en_n_lvl = pins_lvl[`SCDL_PIN_EN_N];
   assign sel_lvl = pins_lvl[`SCDL_PIN_SEL];
   assign sw_lvl = pins_lvl[`SCDL_PIN_SW];

   // ****************************************************************
   // Edge detection.
   // ****************************************************************
   reg sclk_prev_r;
   reg en_n_prev_r;

   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sclk_prev_r <= 1'b0;
         en_n_prev_r <= 1'b1;
      end else begin
         sclk_prev_r <= sclk_lvl;
         en_n_prev_r <= en_n_lvl;
      end
   end

   wire sclk_rise;
   wire en_fall;
   wire en_rise;

   assign sclk_rise = sclk_lvl & ~sclk_prev_r;
   assign en_fall = en_n_prev_r & ~en_n_lvl;
   assign en_rise = ~en_n_prev_r & en_n_lvl;

   // ****************************************************************
   // Registers.
   // ****************************************************************
   reg state_r;
   reg state_nxt;
   reg [`SCDL_WORD_W-1:0] shift_r;
   reg [`SCDL_WORD_W-1:0] shift_nxt;
   reg [`SCDL_CNT_W-1:0] cnt_r;
   reg [`SCDL_CNT_W-1:0] cnt_nxt;
   reg [`SCDL_WORD_W-1:0] hold_r;
   reg [`SCDL_WORD_W-1:0] hold_nxt;
   reg prog_mode_r;
   reg prog_mode_nxt;
   reg mode_out_r;
   reg mode_out_nxt;
   reg busy_r;
   reg busy_nxt;
   reg update_r;
   reg update_nxt;
   reg reject_r;
   reg reject_nxt;
   reg overrun_r;
   reg overrun_nxt;
   reg [`SCDL_CNT_W-1:0] last_cnt_r;
   reg [`SCDL_CNT_W-1:0] last_cnt_nxt;

   // ****************************************************************
   // Frame sequencing.
   // ****************************************************************
   always @* begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      hold_nxt = hold_r;
      prog_mode_nxt = prog_mode_r;
      busy_nxt = busy_r;
      update_nxt = 1'b0;
      reject_nxt = 1'b0;
      overrun_nxt = overrun_r;
      last_cnt_nxt = last_cnt_r;
      case (state_r)
         ST_IDLE: begin
            // Clock and data are not looked at while enable is high.
            if (en_fall) begin
               state_nxt = ST_LOAD;
               cnt_nxt = {`SCDL_CNT_W{1'b0}};
               busy_nxt = 1'b1;
            end
         end
         ST_LOAD: begin
            if (en_rise) begin
               state_nxt = ST_IDLE;
               busy_nxt = 1'b0;
               last_cnt_nxt = cnt_r;
               overrun_nxt = (cnt_r > `SCDL_WORD_CLKS);
               if (cnt_r >= `SCDL_MIN_CLKS) begin
                  hold_nxt = shift_r;
                  prog_mode_nxt = shift_r[`SCDL_MODE_BIT];
                  update_nxt = 1'b1;
               end else begin
                  reject_nxt = 1'b1;
               end
            end else if (!en_n_lvl && sclk_rise) begin
               shift_nxt = {shift_r[`SCDL_WORD_W-2:0], sdata_lvl};
               if (cnt_r != `SCDL_CNT_MAX) begin
                  cnt_nxt = cnt_r + 5'h01;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            busy_nxt = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Output mode selection.
   // ****************************************************************
   always @* begin
      if (sel_lvl) begin
         mode_out_nxt = prog_mode_nxt;
      end else begin
         mode_out_nxt = sw_lvl;
      end
   end

   // ****************************************************************
   // State update.
   // ****************************************************************
   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= ST_IDLE;
         shift_r <= {`SCDL_WORD_W{1'b0}};
         cnt_r <= {`SCDL_CNT_W{1'b0}};
         hold_r <= `SCDL_DAC_RST;
         prog_mode_r <= `SCDL_MODE_RST;
         mode_out_r <= 1'b0;
         busy_r <= 1'b0;
         update_r <= 1'b0;
         reject_r <= 1'b0;
         overrun_r <= 1'b0;
         last_cnt_r <= {`SCDL_CNT_W{1'b0}};
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
         hold_r <= hold_nxt;
         prog_mode_r <= prog_mode_nxt;
         mode_out_r <= mode_out_nxt;
         busy_r <= busy_nxt;
         update_r <= update_nxt;
         reject_r <= reject_nxt;
         overrun_r <= overrun_nxt;
         last_cnt_r <= last_cnt_nxt;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign control_dac_output_o = hold_r;
   assign output_mode_normal_o = mode_out_r;
   assign load_busy_o = busy_r;
   assign dac_update_o = update_r;
   assign frame_reject_o = reject_r;
   assign frame_overrun_o = overrun_r;
   assign frame_clk_count_o = last_cnt_r;

endmodule
`default_nettype wire

// [verification/scdl_monitor.sv]
// Checker for the serial control DAC loader ports.
`timescale 1ns/100ps
`default_nettype none
module scdl_monitor (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic serial_load_enable_n_i,
   input wire logic output_mode_select_i,
   input wire logic [11:0] control_dac_output_o,
   input wire logic output_mode_normal_o,
   input wire logic load_busy_o,
   input wire logic dac_update_o,
   input wire logic frame_reject_o,
   input wire logic frame_overrun_o,
   input wire logic [4:0] frame_clk_count_o
);
default clocking @(posedge clock_i); endclocking
default disable iff (sys_rst_i);
chk_pulse_excl: assert property (!(dac_update_o && frame_reject_o))
   else $error("update and reject together");
chk_update_once: assert property (dac_update_o |=> !dac_update_o)
   else $error("update pulse too long");
chk_word_hold: assert property (!dac_update_o |-> $stable(control_dac_output_o))
   else $error("word changed without update");
chk_update_count: assert property (dac_update_o |-> frame_clk_count_o >= 5'h03)
   else $error("update on short frame");
chk_reject_count: assert property (frame_reject_o |-> frame_clk_count_o < 5'h03)
   else $error("reject on long frame");
chk_overrun_flag: assert property ((dac_update_o || frame_reject_o) |->
   frame_overrun_o == (frame_clk_count_o > 5'h0C)) else $error("overrun flag wrong");
chk_busy_start: assert property ($fell(serial_load_enable_n_i) |-> ##[2:6] load_busy_o)
   else $error("frame did not open");
chk_frame_close: assert property (load_busy_o && $rose(serial_load_enable_n_i) |->
   ##[1:6] (!load_busy_o && (dac_update_o || frame_reject_o))) else $error("frame did not close");
chk_mode_prog: assert property (dac_update_o && output_mode_select_i && $past(output_mode_select_i, 6) |->
   output_mode_normal_o == control_dac_output_o[11]) else $error("programmed mode wrong");
endmodule
bind scdl_loader scdl_monitor mon (.clock_i, .sys_rst_i, .serial_load_enable_n_i, .output_mode_select_i,
   .control_dac_output_o, .output_mode_normal_o, .load_busy_o, .dac_update_o, .frame_reject_o,
   .frame_overrun_o, .frame_clk_count_o);
`default_nettype wire

// [verification/scdl_host.sv]
// Host controller model that drives the three serial load lines.
`timescale 1ns/100ps
`default_nettype none
module scdl_host (
   input wire logic clock_i,
   output logic bit_clk_o,
   output logic data_o,
   output logic enable_n_o
);
initial begin
   bit_clk_o = 1'b0;
   data_o = 1'b0;
   enable_n_o = 1'b1;
end
task automatic half;
   repeat (4) @(posedge clock_i);
   #1;
endtask
task automatic frame(input logic [31:0] w, input int n, input logic en);
   half();
   enable_n_o = en;
   half();
   for (int i = n - 1; i >= 0; i--) begin
      data_o = w[i];
      half();
      bit_clk_o = 1'b1;
      half();
      bit_clk_o = 1'b0;
      data_o = ~data_o;
   end
   half();
   enable_n_o = 1'b1;
   half();
endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking testbench for the serial control DAC loader.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
logic clock_i, sys_rst_i, sel, sw, bclk, bdat, ben_n, upd, rej, ovr, normal, busy, known;
logic [11:0] word, ew;
logic [4:0] cnt;
logic [31:0] seed, w;
logic [63:0] sr;
int error_cnt, compares, nupd, nrej;
int lens[10] = '{12, 3, 2, 0, 13, 1, 12, 20, 11, 4};
scdl_loader uut (.clock_i, .sys_rst_i, .serial_bit_clk_i(bclk), .serial_data_in_i(bdat),
   .serial_load_enable_n_i(ben_n), .output_mode_select_i(sel), .output_mode_switch_i(sw),
   .control_dac_output_o(word), .output_mode_normal_o(normal), .load_busy_o(busy), .dac_update_o(upd),
   .frame_reject_o(rej), .frame_overrun_o(ovr), .frame_clk_count_o(cnt));
scdl_host host (.clock_i, .bit_clk_o(bclk), .data_o(bdat), .enable_n_o(ben_n));
function automatic logic [31:0] rnd();
   seed ^= seed << 13;
   seed ^= seed >> 17;
   seed ^= seed << 5;
   return seed;
endfunction
function automatic logic [11:0] mask(int n);
   return n >= 12 ? 12'hFFF : (12'h001 << n) - 12'h001;
endfunction
task automatic wrap_up;
   $display("compares %0d error_cnt %0d", compares, error_cnt);
   if (error_cnt == 0 && compares > 0) $display("All tests passed");
   else $display("Some tests failed");
   $finish;
endtask
always @(posedge clock_i) begin
   if (upd === 1'b1) nupd++;
   if (rej === 1'b1) nrej++;
end
initial begin
   clock_i = 1'b0;
   forever #50 clock_i = ~clock_i;
end
initial begin
   #2_000_000;
   error_cnt++;
   wrap_up();
end
initial begin
   sys_rst_i = 1'b1;
   sel = 1'b0;
   sw = 1'b0;
   seed = 32'h35;
   sr = 64'h0;
   known = 1'b0;
   ew = 12'h000;
   repeat (20) @(posedge clock_i);
   #1 sys_rst_i = 1'b0;
   for (int k = 0; k < 30; k++) begin
      int n, pu, pr;
      logic [11:0] pw;
      w = rnd();
      n = k < 10 ? lens[k] : w[31:28] + 1;
      pu = nupd;
      pr = nrej;
      pw = word;
      host.frame(w, n, k % 7 == 6);
      sel = w[27];
      sw = w[26];
      repeat (8) @(posedge clock_i);
      #1;
      `CHK(busy, 1'b0)
      if (k % 7 == 6) begin
         `CHK(word, pw)
         `CHK(nupd + nrej, pu + pr)
      end else begin
         for (int i = n - 1; i >= 0; i--) sr = {sr[62:0], w[i]};
         `CHK(cnt, 5'(n))
         `CHK(ovr, n > 12)
         `CHK(nupd - pu, int'(n >= 3))
         `CHK(nrej - pr, int'(n < 3))
         if (n >= 3) `CHK(word & mask(n), sr[11:0] & mask(n))
         else `CHK(word, pw)
         if (n >= 12) ew = sr[11:0];
         if (n >= 3) known = n >= 12;
      end
      if (!sel || known) `CHK(normal, sel ? ew[11] : sw)
   end
   wrap_up();
end
endmodule
`default_nettype wire
